/* File: bench/scp_host.sv */
`timescale 1ns/100ps
module scp_host (
    input wire logic ref_clk,
    output logic sclk,
    output logic sdata
);
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
    end
    // ========
    // Pin sequencing
    // ========
    // six cycles a level, far inside time-out
    task automatic lvl(input logic c, input logic d);
        @(negedge ref_clk);
        sclk = c;
        sdata = d;
        repeat (5) @(negedge ref_clk);
    endtask
    // complement before fall, true value before rise
    task automatic pair(input logic f, input logic r);
        lvl(1'b1, f);
        lvl(1'b0, f);
        lvl(1'b0, r);
        lvl(1'b1, r);
    endtask
    // unlock edges, then start bit s
    task automatic unlock(input int n, input logic s);
        repeat (n) begin
            lvl(1'b0, 1'b1);
            lvl(1'b1, 1'b1);
        end
        lvl(1'b0, 1'b0);
        lvl(1'b1, 1'b0);
        pair(s, s);
    endtask
    task automatic word(input logic [23:0] w, input int len);
        for (int i = 0; i < len; i++) begin
            pair(~w[23 - i % 24], w[23 - i % 24]);
        end
    endtask
    // stop pair, then pins back to pull-down level
    task automatic stop(input logic s);
        pair(s, s);
        lvl(1'b0, 1'b0);
    endtask
endmodule

/* File: bench/scp_prog_port_assertions.sv */
`timescale 1ns/100ps
module scp_prog_port_checker
    import scp_pkg::*;
#(
    parameter int TIMEOUT_CYCLES_P = TIMEOUT_CYCLES
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic select_a_serial_clock_pin,
    input wire logic select_b_serial_data_pin,
    input wire logic power_down_n_pin,
    input wire logic program_error_n,
    input wire scp_regs_t regs,
    input wire scp_video_clock_out_t video_clock_out_ctl,
    input wire scp_power_t power_ctl,
    input wire logic prog_busy
);
    // ========
    // Pin quiet counter
    // ========
    logic [1:0] pins;
    logic [1:0] pins_q;
    // Wide enough for the full default time-out count
    logic [17:0] quiet_q;
    logic [17:0] quiet_d;
    assign pins = {select_b_serial_data_pin, select_a_serial_clock_pin};
    always_comb begin
        quiet_d = quiet_q;
        if (pins_q != pins) begin
            quiet_d = 18'h00000;
        end else if (quiet_q != 18'h3FFFF) begin
            quiet_d = quiet_q + 18'h00001;
        end
    end
    always_ff @(posedge ref_clk) begin
        pins_q <= pins;
        quiet_q <= srst ? 18'h00000 : quiet_d;
    end
    // ========
    // Properties
    // ========
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    chk_err_reset:
        assert property ($fell(srst) |-> program_error_n)
        else $error("error flag low after reset");
    chk_pd_mode:
        assert property (!power_down_n_pin [*5] |->
            power_ctl.video_clock_out_forced_high &&
            power_ctl.osc_stop == regs.control[18] &&
            power_ctl.outputs_off == regs.control[18] &&
            power_ctl.mclk_standby == !regs.control[18])
        else $error("power-down action wrong");
    chk_src_bit:
        assert property ($stable(regs.control) |->
            video_clock_out_ctl.src_mclk == regs.control[17])
        else $error("change source wrong");
    chk_duty_trim:
        assert property ($stable(regs.control) |->
            video_clock_out_ctl.duty_trim == !regs.control[14])
        else $error("duty trim wrong");
    chk_prescale:
        assert property ($stable(regs.control) |->
            video_clock_out_ctl.prescale_by4 == regs.control[12:10])
        else $error("prescale wrong");
    chk_sel_quiet:
        assert property ($changed(video_clock_out_ctl.select) |->
            quiet_q >= 18'(TIMEOUT_CYCLES_P - 4))
        else $error("selection moved before time-out");
    chk_err_hold:
        assert property ($fell(program_error_n) |=> !program_error_n [*8])
        else $error("error flag released early");
    chk_err_clear:
        assert property ($rose(program_error_n) |->
            $past(srst) || $past(select_b_serial_data_pin, 4))
        else $error("error flag cleared without unlock");
    chk_load_idle:
        assert property ($changed(regs) |-> ##[0:2] !prog_busy)
        else $error("engine not locked after load");
    chk_pd_refuse:
        assert property (!power_down_n_pin [*6] |-> !prog_busy)
        else $error("engine active in power-down");
    chk_err_cause:
        assert property ($fell(program_error_n) |-> $past(prog_busy))
        else $error("error flag with idle engine");
endmodule

bind scp_prog_port scp_prog_port_checker #(
    .TIMEOUT_CYCLES_P(TIMEOUT_CYCLES_P)
) i_scp_prog_port_checker (.ref_clk, .srst, .select_a_serial_clock_pin,
    .select_b_serial_data_pin, .power_down_n_pin, .program_error_n,
    .regs, .video_clock_out_ctl, .power_ctl, .prog_busy);

/* File: bench/scp_prog_port_tb.sv */
`timescale 1ns/100ps
module scp_prog_port_tb import scp_pkg::*; ;
    localparam int TO = 64;
    logic ref_clk;
    logic srst = 1'b1;
    logic pd_n = 1'b1;
    logic sclk;
    logic sdata;
    logic err_n;
    logic busy;
    scp_regs_t regs;
    scp_regs_t er;
    scp_video_clock_out_t video_clock_out;
    scp_power_t pwr;
    logic [20:0] d;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int nb[5] = '{0, 3, 23, 25, 24};

    scp_host i_scp_host (.ref_clk, .sclk, .sdata);
    scp_prog_port #(.TIMEOUT_CYCLES_P(TO)) i_scp_prog_port (
        .ref_clk, .srst, .select_a_serial_clock_pin(sclk),
        .select_b_serial_data_pin(sdata), .power_down_n_pin(pd_n),
        .program_error_n(err_n), .regs, .video_clock_out_ctl(video_clock_out),
        .power_ctl(pwr), .prog_busy(busy));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors++;
            results();
        end
    end
    // ========
    // Helpers
    // ========
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic results();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk_regs(input scp_regs_t got, input scp_regs_t exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic [3:0] got, input logic [3:0] exp);
        chk_regs(126'(got), 126'(exp));
    endtask
    function automatic void put(input logic [2:0] a, input logic [20:0] v);
        case (a)
            ADDR_VIDEO_A, ADDR_VIDEO_B, ADDR_VIDEO_C: er.video[a[1:0]] = v;
            ADDR_MEMORY: er.memory = v;
            ADDR_STANDBY: er.standby = v;
            ADDR_CONTROL: er.control = v;
            default: ;
        endcase
    endfunction
    task automatic prog(input logic [20:0] v, input logic [2:0] a);
        i_scp_host.unlock(5, 1'b0);
        i_scp_host.word({v, a}, 24);
        i_scp_host.stop(1'b1);
        wt(8);
    endtask
    // ========
    // Sequence
    // ========
    initial begin
        er = {{3{VIDEO_RESET}}, MEMORY_RESET, STANDBY_RESET, CTRL_RESET};
        wt(16);
        srst = 1'b0;
        wt(4);
        chk_regs(regs, er);
        chk_flag({3'h0, err_n}, 4'h1);
        chk_flag({video_clock_out.duty_trim, 3'h0}, 4'h0);
        // Unassigned 101 and 111 must leave everything alone
        for (int i = 0; i < 8; i++) begin
            d = (i == 6) ? 21'h021400 : 21'(21'h0B5A3C + i * 21'h01F0F1);
            prog(d, 3'(i));
            put(3'(i), d);
            chk_regs(regs, er);
        end
        chk_flag({3'h0, err_n}, 4'h1);
        chk_flag({video_clock_out.src_mclk, video_clock_out.prescale_by4}, 4'hD);
        chk_flag({video_clock_out.duty_trim, 3'h0}, 4'h8);
        // Stop right at the fault, so later rises cannot clear it
        for (int k = 0; k < 5; k++) begin
            i_scp_host.unlock(5, k == 0);
            i_scp_host.word({~er.video[0], ADDR_VIDEO_A}, nb[k]);
            if (k == 1 || k == 2) i_scp_host.pair(1'b1, 1'b1);
            if (k == 4) i_scp_host.pair(1'b0, 1'b0);
            i_scp_host.lvl(1'b0, 1'b0);
            chk_flag({3'h0, err_n}, 4'h0);
            chk_regs(regs, er);
        end
        i_scp_host.unlock(4, 1'b0);
        i_scp_host.word(24'h000000, 24);
        i_scp_host.stop(1'b1);
        chk_flag({3'h0, err_n}, 4'h1);
        chk_regs(regs, er);
        i_scp_host.unlock(5, 1'b0);
        i_scp_host.word(24'hFFC000, 10);
        wt(3 * TO);
        i_scp_host.word(24'h000000, 14);
        i_scp_host.stop(1'b1);
        chk_regs(regs, er);
        chk_flag({3'h0, err_n}, 4'h1);
        d = 21'h031400;
        prog(d, ADDR_CONTROL);
        put(ADDR_CONTROL, d);
        wt(3 * TO);
        i_scp_host.lvl(1'b1, 1'b0);
        wt(TO + 16);
        chk_flag({2'h0, video_clock_out.select}, 4'h0);
        wt(TO + 16);
        chk_flag({2'h0, video_clock_out.select}, 4'h1);
        // New selection opens the change window for two more time-outs
        chk_flag({3'h0, video_clock_out.changing}, 4'h1);
        wt(4 * TO + 16);
        chk_flag({3'h0, video_clock_out.changing}, 4'h0);
        pd_n = 1'b0;
        wt(8);
        chk_flag(pwr, 4'h3);
        prog(21'h1FFFFF, ADDR_VIDEO_A);
        chk_regs(regs, er);
        pd_n = 1'b1;
        wt(8);
        d = 21'h071400;
        prog(d, ADDR_CONTROL);
        put(ADDR_CONTROL, d);
        pd_n = 1'b0;
        wt(8);
        chk_flag(pwr, 4'hD);
        results();
    end
endmodule

/* File: design/scp_prog_port.sv */
// Behaviour
// - Power-down mode bit picks standby action
// - Change-source bit picks clock during changes
// - Time-out bit doubles watchdog interval
// - Cleared duty bit shortens high time
// - Prescale bits: zero by two, one four
// - No programming while powered down
// - Select A is clock, select B data
// - Five high edges then low unlocks
// - Every clock or data pin transition restarts watchdog
// - Time-out relocks and drops shift data
// - Selection updates only at time-out
// - Complement on fall, true on rise
// - Start, 21 data, 3 address, stop
// - Exactly 24 bits, else error, unless time-out drops the short word
// - Valid stop loads addressed register
// - Load relocks, selection waits time-out
// - Extra data after full word errors
// - Error low until next unlock begins
// - Error on start, coding, length, stop
// - Video selection frozen while shifting
// - Address decode to six registers
`timescale 1ns/100ps
module scp_prog_port
    import scp_pkg::*;
#(
    parameter int TIMEOUT_CYCLES_P = TIMEOUT_CYCLES
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic select_a_serial_clock_pin,
    input wire logic select_b_serial_data_pin,
    input wire logic power_down_n_pin,
    output logic program_error_n,
    output scp_regs_t regs,
    output scp_video_clock_out_t video_clock_out_ctl,
    output scp_power_t power_ctl,
    output logic prog_busy
);

    // ========================================================
    // State
    // ========================================================
    typedef struct packed {
        scp_state_t st;
        logic [2:0] ucnt;
        logic [4:0] bcnt;
        logic comp;
        logic have_fall;
        logic [SHIFT_LEN-1:0] sreg;
        logic err;
        logic sclk_p;
        logic sdata_p;
        logic [1:0] sel;
        logic [1:0] chg_left;
        scp_regs_t r;
    } scp_core_t;

    localparam scp_core_t CORE_RESET = '{
        st: ST_LOCKED,
        ucnt: 3'h0,
        bcnt: 5'h00,
        comp: 1'b0,
        have_fall: 1'b0,
        sreg: 24'h000000,
        err: 1'b0,
        sclk_p: 1'b0,
        sdata_p: 1'b0,
        sel: 2'h0,
        chg_left: 2'h0,
        r: '{video: {VIDEO_RESET, VIDEO_RESET, VIDEO_RESET},
             memory: MEMORY_RESET,
             standby: STANDBY_RESET,
             control: CTRL_RESET}
    };

    scp_core_t s_q;
    scp_core_t s_d;
    scp_pins_t pins;
    logic wd_timeout;
    logic wd_restart;
    logic pd_active;
    logic rise;
    logic fall;
    logic sclk;
    logic sdata;
    logic [2:0] ld_addr;
    logic [20:0] ld_data;
    logic [1:0] sel_new;

    // ========================================================
    // Pin capture and watchdog
    // ========================================================
    scp_sync u_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .pins_async('{sclk: select_a_serial_clock_pin,
                      sdata: select_b_serial_data_pin,
                      pd_n: power_down_n_pin}),
        .pins_sync(pins)
    );

    assign sclk = pins.sclk;
    assign sdata = pins.sdata;
    assign pd_active = ~pins.pd_n;
    assign rise = sclk & ~s_q.sclk_p;
    assign fall = ~sclk & s_q.sclk_p;

    assign wd_restart = (sclk ^ s_q.sclk_p) | (sdata ^ s_q.sdata_p);

    scp_watchdog #(
        .TIMEOUT_CYCLES_P(TIMEOUT_CYCLES_P)
    ) u_wdog (
        .ref_clk(ref_clk),
        .srst(srst),
        .restart(wd_restart),
        .double_len(ctrl_bit(s_q.r.control, POS_TO_DBL)),
        .timeout(wd_timeout)
    );

    // ========================================================
    // Serial engine
    // ========================================================
    always_comb begin
        s_d = s_q;
        s_d.sclk_p = sclk;
        s_d.sdata_p = sdata;
        ld_addr = s_q.sreg[ADDR_W-1:0];
        ld_data = s_q.sreg[SHIFT_LEN-1:DATA_LSB];
        // Select pins read as a pair {data line, clock line}
        sel_new = {sdata, sclk};

        // Selection only follows pins at time-out
        if (wd_timeout) begin
            s_d.sel = sel_new;
            if (sel_new != s_q.sel) begin
                s_d.chg_left = 2'h2;
            end else if (s_q.chg_left != 2'h0) begin
                s_d.chg_left = s_q.chg_left - 2'h1;
            end
        end

        if (pd_active || wd_timeout) begin
            s_d.st = ST_LOCKED;
            s_d.ucnt = 3'h0;
            s_d.bcnt = 5'h00;
            s_d.have_fall = 1'b0;
            s_d.sreg = '0;
        end else begin
            unique case (s_q.st)
                ST_LOCKED: begin
                    if (rise && sdata) begin
                        if (s_q.ucnt == 3'h0) begin
                            s_d.err = 1'b0;
                        end
                        if (s_q.ucnt != UNLOCK_SAT) begin
                            s_d.ucnt = s_q.ucnt + 3'h1;
                        end
                    end else if (rise) begin
                        if (s_q.ucnt == UNLOCK_SAT) begin
                            s_d.st = ST_START;
                            s_d.have_fall = 1'b0;
                        end
                        s_d.ucnt = 3'h0;
                    end else if (s_q.sdata_p && !sdata &&
                                 s_q.ucnt != UNLOCK_SAT) begin
                        s_d.ucnt = 3'h0;
                    end
                end
                ST_START: begin
                    if (fall) begin
                        s_d.comp = sdata;
                        s_d.have_fall = 1'b1;
                    end else if (rise && s_q.have_fall) begin
                        s_d.have_fall = 1'b0;
                        // Start bit is low on both edges
                        if (!s_q.comp && !sdata) begin
                            s_d.st = ST_SHIFT;
                            s_d.bcnt = 5'h00;
                        end else begin
                            s_d.err = 1'b1;
                            s_d.st = ST_LOCKED;
                        end
                    end
                end
                ST_SHIFT: begin
                    if (fall) begin
                        s_d.comp = sdata;
                        s_d.have_fall = 1'b1;
                    end else if (rise && s_q.have_fall) begin
                        s_d.have_fall = 1'b0;
                        if (s_q.comp == sdata) begin
                            s_d.err = 1'b1;
                            s_d.st = ST_LOCKED;
                            s_d.sreg = '0;
                        end else begin
                            s_d.sreg = {s_q.sreg[SHIFT_LEN-2:0], sdata};
                            s_d.bcnt = s_q.bcnt + 5'h01;
                            if (s_q.bcnt == LAST_BIT) begin
                                s_d.st = ST_STOP;
                            end
                        end
                    end
                end
                ST_STOP: begin
                    if (fall) begin
                        s_d.comp = sdata;
                        s_d.have_fall = 1'b1;
                    end else if (rise && s_q.have_fall) begin
                        s_d.have_fall = 1'b0;
                        s_d.st = ST_LOCKED;
                        s_d.sreg = '0;
                        s_d.bcnt = 5'h00;
                        if (s_q.comp && sdata) begin
                            unique case (ld_addr)
                                ADDR_VIDEO_A, ADDR_VIDEO_B,
                                ADDR_VIDEO_C: begin
                                    s_d.r.video[ld_addr[1:0]] = ld_data;
                                    if (ld_addr[1:0] == s_q.sel) begin
                                        s_d.chg_left = 2'h2;
                                    end
                                end
                                ADDR_MEMORY: begin
                                    s_d.r.memory = ld_data;
                                    s_d.chg_left = 2'h2;
                                end
                                ADDR_STANDBY: s_d.r.standby = ld_data;
                                ADDR_CONTROL: s_d.r.control = ld_data;
                                // Unassigned addresses drop the word
                                default: s_d.err = s_q.err;
                            endcase
                        end else begin
                            // Extra data or bad stop errors
                            s_d.err = 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // Error flag clear out of reset
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_q <= CORE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ========================================================
    // Outputs
    // ========================================================
    // Active-low error
    assign program_error_n = ~s_q.err;
    assign regs = s_q.r;
    assign prog_busy = (s_q.st != ST_LOCKED) || (s_q.ucnt != 3'h0);

    always_comb begin
        // Video select held while bits shift
        video_clock_out_ctl.select = s_q.sel;
        video_clock_out_ctl.changing = s_q.chg_left != 2'h0;
        video_clock_out_ctl.src_mclk = ctrl_bit(s_q.r.control, POS_CHG_SRC);
        video_clock_out_ctl.prescale_by4 = {ctrl_bit(s_q.r.control, POS_PRE_C),
                                 ctrl_bit(s_q.r.control, POS_PRE_B),
                                 ctrl_bit(s_q.r.control, POS_PRE_A)};
        // Trim active when bit is clear
        video_clock_out_ctl.duty_trim = ~ctrl_bit(s_q.r.control, POS_DUTY);
    end

    always_comb begin
        power_ctl.osc_stop =
            pd_active & ctrl_bit(s_q.r.control, POS_PD_MODE);
        power_ctl.outputs_off = power_ctl.osc_stop;
        power_ctl.mclk_standby =
            pd_active & ~ctrl_bit(s_q.r.control, POS_PD_MODE);
        power_ctl.video_clock_out_forced_high = pd_active;
    end

endmodule

/* File: design/scp_sync.sv */
`timescale 1ns/100ps
module scp_sync
    import scp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire scp_pins_t pins_async,
    output scp_pins_t pins_sync
);
    typedef struct packed {
        scp_pins_t meta;
        scp_pins_t stable;
    } scp_sync_st_t;

    scp_sync_st_t s_q;
    scp_sync_st_t s_d;

    always_comb begin
        s_d.meta = pins_async;
        s_d.stable = s_q.meta;
    end

    // Power-down pin idles high, select pins idle low
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_q <= '{meta: 3'h1, stable: 3'h1};
        end else begin
            s_q <= s_d;
        end
    end

    assign pins_sync = s_q.stable;
endmodule

/* File: design/scp_watchdog.sv */
`timescale 1ns/100ps
module scp_watchdog
    import scp_pkg::*;
#(
    parameter int TIMEOUT_CYCLES_P = TIMEOUT_CYCLES
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic restart,
    input wire logic double_len,
    output logic timeout
);
    typedef struct packed {
        logic [WDOG_W-1:0] cnt;
        logic fire;
    } scp_wd_st_t;

    localparam logic [WDOG_W-1:0] LIM_N = WDOG_W'(TIMEOUT_CYCLES_P - 1);
    localparam logic [WDOG_W-1:0] LIM_D =
        WDOG_W'(2 * TIMEOUT_CYCLES_P - 1);

    scp_wd_st_t s_q;
    scp_wd_st_t s_d;
    logic [WDOG_W-1:0] limit;

    always_comb begin
        limit = double_len ? LIM_D : LIM_N;
        s_d = s_q;
        s_d.fire = 1'b0;
        if (restart) begin
            s_d.cnt = '0;
        end else if (s_q.cnt >= limit) begin
            // Free running: a quiet line times out once per interval
            s_d.cnt = '0;
            s_d.fire = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + WDOG_W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign timeout = s_q.fire;
endmodule

/* File: include/scp_pkg.sv */
package scp_pkg;

    // ========================================================
    // Timing
    // ========================================================
    localparam int CLK_HZ = 40_000_000;
    localparam int TIMEOUT_MS = 2;
    // Longest gap between edges, so rounded down
    localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int WDOG_W = 18;

    // ========================================================
    // Serial word layout
    // ========================================================
    localparam int SHIFT_LEN = 24;
    localparam int DATA_W = 21;
    localparam int ADDR_W = 3;
    localparam int DATA_LSB = 3;
    localparam int UNLOCK_MIN = 5;
    localparam logic [4:0] LAST_BIT = 5'h17;
    localparam logic [2:0] UNLOCK_SAT = 3'h5;

    // ========================================================
    // Register addresses
    // ========================================================
    localparam logic [2:0] ADDR_VIDEO_A = 3'h0;
    localparam logic [2:0] ADDR_VIDEO_B = 3'h1;
    localparam logic [2:0] ADDR_VIDEO_C = 3'h2;
    localparam logic [2:0] ADDR_MEMORY = 3'h3;
    localparam logic [2:0] ADDR_STANDBY = 3'h4;
    localparam logic [2:0] ADDR_CONTROL = 3'h6;

    // ========================================================
    // Control field positions, numbered within the serial word
    // ========================================================
    localparam int POS_PD_MODE = 21;
    localparam int POS_CHG_SRC = 20;
    localparam int POS_TO_DBL = 19;
    localparam int POS_RSV_HI = 18;
    localparam int POS_DUTY = 17;
    localparam int POS_RSV_LO = 16;
    localparam int POS_PRE_C = 15;
    localparam int POS_PRE_B = 14;
    localparam int POS_PRE_A = 13;

    // ========================================================
    // Reset values
    // ========================================================
    localparam logic [20:0] CTRL_RESET = 21'h004000;
    localparam logic [20:0] VIDEO_RESET = 21'h000000;
    localparam logic [20:0] MEMORY_RESET = 21'h000000;
    localparam logic [20:0] STANDBY_RESET = 21'h000008;

    // ========================================================
    // Types
    // ========================================================
    typedef enum logic [1:0] {
        ST_LOCKED,
        ST_START,
        ST_SHIFT,
        ST_STOP
    } scp_state_t;

    typedef struct packed {
        logic sclk;
        logic sdata;
        logic pd_n;
    } scp_pins_t;

    typedef struct packed {
        logic osc_stop;
        logic outputs_off;
        logic mclk_standby;
        logic video_clock_out_forced_high;
    } scp_power_t;

    typedef struct packed {
        logic [1:0] select;
        logic changing;
        logic src_mclk;
        logic [2:0] prescale_by4;
        logic duty_trim;
    } scp_video_clock_out_t;

    typedef struct packed {
        logic [2:0][20:0] video;
        logic [20:0] memory;
        logic [20:0] standby;
        logic [20:0] control;
    } scp_regs_t;

    function automatic logic ctrl_bit(input logic [20:0] c,
                                      input int pos);
        return c[pos - DATA_LSB];
    endfunction

endpackage
